// ==== shared/i2ce_pkg.sv ====
/*
 * Shared constants, encodings and state type for the two-wire engine.
 * Assumes a 40 MHz system clock and open-drain pads outside the block.
 */
package i2ce_pkg;

	// System clock and bus bit times
	localparam int CLK_PERIOD_NS = 25;
	localparam int STD_BIT_NS    = 10000;
	localparam int FAST_BIT_NS   = 2500;
	localparam int QTRS_PER_BIT  = 4;

	// Quarter-bit counts, derived from the bit times
	localparam logic [6:0] QTR_STD_CYC =
		7'(STD_BIT_NS / QTRS_PER_BIT / CLK_PERIOD_NS);
	localparam logic [6:0] QTR_FAST_CYC =
		7'(FAST_BIT_NS / QTRS_PER_BIT / CLK_PERIOD_NS);

	// Data path
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;

	// Byte framing
	localparam logic [3:0] ACK_SLOT      = 4'h8;
	localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
	localparam logic       DIR_WRITE     = 1'h0;
	localparam logic       DIR_READ      = 1'h1;

	// Quarter phases within one bit
	localparam logic [1:0] PH_LOW0  = 2'h0;
	localparam logic [1:0] PH_LOW1  = 2'h1;
	localparam logic [1:0] PH_HIGH0 = 2'h2;
	localparam logic [1:0] PH_HIGH1 = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_BYTE  = 3'b010,
		ST_STOP  = 3'b011,
		ST_SLAVE = 3'b100
	} i2ce_state_t;

endpackage : i2ce_pkg

// ==== rtl/i2ce_engine.sv ====
/*
 * Two-wire bus protocol engine (master and slave) with its transmit FIFO.
 * Assumes external open-drain pads with pull-ups, and user logic on i_clk
 * for commands, transmit data and the acknowledge and address controls.
 */
`timescale 1ns/10ps

module i2ce_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	// Fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Drain side
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr_ff;
	logic [PW-1:0]    rd_ptr_ff;
	logic [CW-1:0]    count_ff;
	logic [CW-1:0]    nxt_count;
	logic             ready_ff;
	logic             push;
	logic             pop;

	assign push        = i_in_valid && ready_ff;
	assign pop         = i_out_ready && (count_ff != '0);
	assign o_in_ready  = ready_ff;
	assign o_out_valid = (count_ff != '0);
	assign o_out_data  = mem[rd_ptr_ff];

	always_comb begin
		nxt_count = count_ff;
		if (push && !pop) begin
			nxt_count = count_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	// Ready is registered so the fill side never sees a combinational path
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_ff <= '0;
			ready_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			ready_ff <= (nxt_count != FULL_CNT);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= i_in_data;
		end
	end

endmodule : i2ce_fifo

// Notes on behaviour
// - Master opens every transfer with START
// - START, address, data bytes, STOP in order
// - Bytes shift most significant bit first
// - Address byte is seven bits plus direction
// - Direction zero writes, one reads
// - Receiver acknowledges received data bytes per the acknowledge-control bit
// - Missing acknowledge counts as not-acknowledge
// - Write waits for slave acknowledge per byte
// - Read waits for master acknowledge per byte
// - Master ends every transfer with STOP, except after lost arbitration
// - Master and slave, transmit and receive roles
// - Master transmitter drives data and clock
// - Write address carries direction bit zero
// - Master receiver samples data, drives clock
// - Read address carries direction bit one
// - Master acknowledge follows acknowledge-control bit
// - Arbitration and clock sync for several masters
// - Exactly two bidirectional lines, data and clock
// - Clock generator gives 100 kHz and 400 kHz
// - Slave roles recognise the general call
// - General call enable gates all-zero address
// - Slave acknowledges its own address, or the general call when enabled
module i2ce_engine (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	// Bus pins
	input  wire logic       i_sda,
	output logic            o_sda,
	output logic            o_sda_oe_n,
	input  wire logic       i_scl,
	output logic            o_scl,
	output logic            o_scl_oe_n,
	// Control
	input  wire logic       i_fast_mode,
	input  wire logic       i_ack_assert_bit,
	input  wire logic       i_general_call_enable,
	input  wire logic [6:0] i_own_address_register,
	// Master command
	input  wire logic       i_start,
	input  wire logic [6:0] i_addr,
	input  wire logic       i_rw,
	input  wire logic [7:0] i_len,
	// Transmit data
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_data,
	output logic            o_tx_ready,
	// Receive data and status
	output logic            o_rx_valid,
	output logic [7:0]      o_rx_data,
	output logic            o_busy,
	output logic            o_done,
	output logic            o_nack,
	output logic            o_arb_lost,
	output logic            o_addressed,
	output logic            o_gc_hit,
	output logic            o_slave_tx
);
	// Reset and pin synchronisers
	logic        rst_meta_ff;
	logic        rst_n_ff;
	logic [1:0]  pin_meta_ff;
	logic [1:0]  pin_sync_ff;
	logic [1:0]  pin_prev_ff;
	logic        sda_s;
	logic        scl_s;
	logic        start_det;
	logic        stop_det;
	logic        scl_rise;
	logic        scl_fall;
	logic        busy_ff;

	// Master state
	i2ce_pkg::i2ce_state_t state_ff;
	logic [1:0]  phase_ff;
	logic [6:0]  qcnt_ff;
	logic [6:0]  qtr_reload;
	logic [3:0]  bit_ff;
	logic [7:0]  sh_ff;
	logic [7:0]  len_ff;
	logic        dir_ff;
	logic        rx_ff;
	logic        addr_ff;
	logic        need_load_ff;
	logic        ack_seen_ff;
	logic        m_sda_low_ff;
	logic        m_scl_low_ff;
	logic        stall;
	logic        tick;
	logic        m_drive;
	logic        m_load;
	logic        m_end;
	logic        m_nack;
	logic        m_last;
	logic        m_lost;
	logic        m_rxbyte;
	logic        m_done;

	// Slave state
	logic [3:0]  s_bit_ff;
	logic [7:0]  s_sh_ff;
	logic        s_addr_ph_ff;
	logic        s_act_ff;
	logic        s_tx_ff;
	logic        s_in_ack_ff;
	logic        s_load_ff;
	logic        s_sda_low_ff;
	logic        s_scl_low_ff;
	logic        s_take;
	logic        s_match;
	logic        s_ack_fall;
	logic        s_rxbyte;
	logic        s_addr_ev;

	// Output registers
	logic        sda_oe_n_ff;
	logic        scl_oe_n_ff;
	logic        pin_zero_ff;
	logic        rx_valid_ff;
	logic [7:0]  rx_data_ff;
	logic        done_ff;
	logic        nack_ff;
	logic        lost_ff;
	logic        addressed_ff;
	logic        gc_hit_ff;
	logic        slave_tx_ff;
	logic        busy_out_ff;

	// FIFO drain side
	logic        fifo_valid;
	logic [7:0]  fifo_data;

	function automatic logic addr_hit(
		input logic [7:0] rx_byte,
		input logic [6:0] own,
		input logic       gc_en
	);
		addr_hit = (rx_byte[7:1] == own) ||
			(gc_en && (rx_byte[7:1] == i2ce_pkg::GEN_CALL_ADDR));
	endfunction : addr_hit

	// Reset: asynchronous assert, synchronous release
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// Pins idle high, so the synchronisers reset to released
	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			pin_meta_ff <= 2'h3;
			pin_sync_ff <= 2'h3;
			pin_prev_ff <= 2'h3;
		end else begin
			pin_meta_ff <= {i_scl, i_sda};
			pin_sync_ff <= pin_meta_ff;
			pin_prev_ff <= pin_sync_ff;
		end
	end

	assign sda_s     = pin_sync_ff[0];
	assign scl_s     = pin_sync_ff[1];
	assign scl_rise  = scl_s && !pin_prev_ff[1];
	assign scl_fall  = !scl_s && pin_prev_ff[1];
	assign start_det = scl_s && pin_prev_ff[1] && pin_prev_ff[0] && !sda_s;
	assign stop_det  = scl_s && pin_prev_ff[1] && !pin_prev_ff[0] && sda_s;

	// Bus busy between any START and the following STOP
	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			busy_ff <= 1'b0;
		end else if (start_det) begin
			busy_ff <= 1'b1;
		end else if (stop_det) begin
			busy_ff <= 1'b0;
		end
	end

	// Quarter-bit timer; a high phase waits while SCL is held low
	assign qtr_reload = i_fast_mode ? i2ce_pkg::QTR_FAST_CYC - 7'h01 :
		i2ce_pkg::QTR_STD_CYC - 7'h01;
	assign stall = ((phase_ff == i2ce_pkg::PH_HIGH0) && !scl_s) ||
		((state_ff == i2ce_pkg::ST_BYTE) && need_load_ff);
	assign tick = (qcnt_ff == 7'h00) && !stall &&
		((state_ff == i2ce_pkg::ST_START) ||
		(state_ff == i2ce_pkg::ST_BYTE) || (state_ff == i2ce_pkg::ST_STOP));

	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			qcnt_ff <= 7'h00;
		end else if (tick || stall || (state_ff == i2ce_pkg::ST_IDLE) ||
			(state_ff == i2ce_pkg::ST_SLAVE)) begin
			qcnt_ff <= qtr_reload;
		end else begin
			qcnt_ff <= qcnt_ff - 7'h01;
		end
	end

	// Master decode
	assign m_drive = (bit_ff == i2ce_pkg::ACK_SLOT) ?
		(rx_ff && i_ack_assert_bit) :
		(!rx_ff && !sh_ff[7]);
	assign m_load  = (state_ff == i2ce_pkg::ST_BYTE) && need_load_ff &&
		fifo_valid;
	assign m_end   = (state_ff == i2ce_pkg::ST_BYTE) && tick &&
		(phase_ff == i2ce_pkg::PH_HIGH1) && (bit_ff == i2ce_pkg::ACK_SLOT);
	assign m_nack  = m_end && !rx_ff && !ack_seen_ff;
	assign m_last  = addr_ff ? (len_ff == 8'h00) : (len_ff == 8'h01);
	assign m_rxbyte = m_end && rx_ff;
	assign m_lost  = (state_ff == i2ce_pkg::ST_BYTE) && tick &&
		(phase_ff == i2ce_pkg::PH_HIGH0) && (bit_ff != i2ce_pkg::ACK_SLOT) &&
		!rx_ff && sh_ff[7] && !sda_s;
	assign m_done  = (state_ff == i2ce_pkg::ST_STOP) && tick &&
		(phase_ff == i2ce_pkg::PH_HIGH1);

	// Master sequencing and role selection
	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			state_ff     <= i2ce_pkg::ST_IDLE;
			phase_ff     <= i2ce_pkg::PH_LOW0;
			bit_ff       <= 4'h0;
			sh_ff        <= 8'h00;
			len_ff       <= 8'h00;
			dir_ff       <= i2ce_pkg::DIR_WRITE;
			rx_ff        <= 1'b0;
			addr_ff      <= 1'b0;
			need_load_ff <= 1'b0;
			ack_seen_ff  <= 1'b0;
			m_sda_low_ff <= 1'b0;
			m_scl_low_ff <= 1'b0;
		end else begin
			case (state_ff)
			i2ce_pkg::ST_IDLE: begin
				m_sda_low_ff <= 1'b0;
				m_scl_low_ff <= 1'b0;
				phase_ff     <= i2ce_pkg::PH_LOW0;
				bit_ff       <= 4'h0;
				if (start_det) begin
					state_ff <= i2ce_pkg::ST_SLAVE;
				end else if (i_start && !busy_ff) begin
					state_ff     <= i2ce_pkg::ST_START;
					sh_ff        <= {i_addr, i_rw};
					dir_ff       <= i_rw;
					len_ff       <= i_len;
					addr_ff      <= 1'b1;
					rx_ff        <= 1'b0;
					need_load_ff <= 1'b0;
				end
			end
			i2ce_pkg::ST_START: begin
				if (tick) begin
					if (phase_ff == i2ce_pkg::PH_LOW0) begin
						m_sda_low_ff <= 1'b1;
						phase_ff     <= i2ce_pkg::PH_LOW1;
					end else begin
						m_scl_low_ff <= 1'b1;
						phase_ff     <= i2ce_pkg::PH_LOW0;
						state_ff     <= i2ce_pkg::ST_BYTE;
					end
				end
			end
			i2ce_pkg::ST_BYTE: begin
				if (m_load) begin
					sh_ff        <= fifo_data;
					need_load_ff <= 1'b0;
				end
				if (phase_ff == i2ce_pkg::PH_LOW0) begin
					m_sda_low_ff <= m_drive;
				end
				if (m_lost) begin
					// Losing master lets go of both lines at once
					state_ff     <= i2ce_pkg::ST_IDLE;
					m_sda_low_ff <= 1'b0;
					m_scl_low_ff <= 1'b0;
				end else if (tick) begin
					phase_ff <= phase_ff + 2'h1;
					case (phase_ff)
					i2ce_pkg::PH_LOW1: begin
						m_scl_low_ff <= 1'b0;
					end
					i2ce_pkg::PH_HIGH0: begin
						if (bit_ff != i2ce_pkg::ACK_SLOT) begin
							sh_ff <= {sh_ff[6:0], rx_ff & sda_s};
						end else begin
							ack_seen_ff <= !sda_s;
						end
					end
					i2ce_pkg::PH_HIGH1: begin
						m_scl_low_ff <= 1'b1;
						if (bit_ff != i2ce_pkg::ACK_SLOT) begin
							bit_ff <= bit_ff + 4'h1;
						end else begin
							bit_ff  <= 4'h0;
							addr_ff <= 1'b0;
							rx_ff   <= dir_ff;
							if (!addr_ff) begin
								len_ff <= len_ff - 8'h01;
							end
							if (m_nack || m_last) begin
								state_ff <= i2ce_pkg::ST_STOP;
							end else begin
								need_load_ff <= (dir_ff == i2ce_pkg::DIR_WRITE);
							end
						end
					end
					default: begin
					end
					endcase
				end
			end
			i2ce_pkg::ST_STOP: begin
				if (phase_ff == i2ce_pkg::PH_LOW0) begin
					m_sda_low_ff <= 1'b1;
				end
				if (tick) begin
					phase_ff <= phase_ff + 2'h1;
					if (phase_ff == i2ce_pkg::PH_LOW1) begin
						m_scl_low_ff <= 1'b0;
					end else if (phase_ff == i2ce_pkg::PH_HIGH1) begin
						m_sda_low_ff <= 1'b0;
						state_ff     <= i2ce_pkg::ST_IDLE;
					end
				end
			end
			i2ce_pkg::ST_SLAVE: begin
				if (stop_det) begin
					state_ff <= i2ce_pkg::ST_IDLE;
				end
			end
			default: begin
				state_ff <= i2ce_pkg::ST_IDLE;
			end
			endcase
		end
	end

	// Slave decode
	assign s_match    = addr_hit(s_sh_ff, i_own_address_register,
		i_general_call_enable);
	assign s_take     = (state_ff == i2ce_pkg::ST_SLAVE) && s_load_ff &&
		fifo_valid;
	assign s_ack_fall = (state_ff == i2ce_pkg::ST_SLAVE) && scl_fall &&
		(s_bit_ff == i2ce_pkg::ACK_SLOT);
	assign s_addr_ev  = s_ack_fall && s_addr_ph_ff && s_match;
	assign s_rxbyte   = s_ack_fall && !s_addr_ph_ff && !s_tx_ff && s_act_ff;

	// Slave receiver and transmitter, stepped by the master's clock
	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			s_bit_ff     <= 4'h0;
			s_sh_ff      <= 8'h00;
			s_addr_ph_ff <= 1'b1;
			s_act_ff     <= 1'b0;
			s_tx_ff      <= 1'b0;
			s_in_ack_ff  <= 1'b0;
			s_load_ff    <= 1'b0;
			s_sda_low_ff <= 1'b0;
			s_scl_low_ff <= 1'b0;
		end else if ((state_ff != i2ce_pkg::ST_SLAVE) || start_det) begin
			s_bit_ff     <= 4'h0;
			s_addr_ph_ff <= 1'b1;
			s_act_ff     <= 1'b1;
			s_tx_ff      <= 1'b0;
			s_in_ack_ff  <= 1'b0;
			s_load_ff    <= 1'b0;
			s_sda_low_ff <= 1'b0;
			s_scl_low_ff <= 1'b0;
		end else begin
			// Empty FIFO stretches the clock instead of sending junk
			if (s_take) begin
				s_sh_ff      <= fifo_data;
				s_sda_low_ff <= !fifo_data[7];
				s_load_ff    <= 1'b0;
				s_scl_low_ff <= 1'b0;
			end else if (s_load_ff) begin
				s_scl_low_ff <= 1'b1;
			end
			if (scl_rise) begin
				if (s_bit_ff != i2ce_pkg::ACK_SLOT) begin
					s_bit_ff <= s_bit_ff + 4'h1;
					if (!s_tx_ff) begin
						s_sh_ff <= {s_sh_ff[6:0], sda_s};
					end
				end else begin
					s_bit_ff <= 4'h0;
					if (s_tx_ff && sda_s) begin
						s_act_ff <= 1'b0;
					end
				end
			end
			if (scl_fall) begin
				if (s_bit_ff == i2ce_pkg::ACK_SLOT) begin
					s_in_ack_ff <= 1'b1;
					if (s_addr_ph_ff) begin
						s_sda_low_ff <= s_match;
						s_act_ff     <= s_match;
						s_tx_ff      <= s_match && (s_sh_ff[0] == i2ce_pkg::DIR_READ);
					end else begin
						s_sda_low_ff <= !s_tx_ff && s_act_ff && i_ack_assert_bit;
					end
				end else if (s_in_ack_ff) begin
					s_in_ack_ff  <= 1'b0;
					s_addr_ph_ff <= 1'b0;
					s_sda_low_ff <= 1'b0;
					s_load_ff    <= s_tx_ff && s_act_ff;
				end else if (s_tx_ff && s_act_ff && (s_bit_ff != 4'h0)) begin
					s_sh_ff      <= {s_sh_ff[6:0], 1'b0};
					s_sda_low_ff <= !s_sh_ff[6];
				end
			end
		end
	end

	// Pins and status; outputs only ever pull low
	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			sda_oe_n_ff  <= 1'b1;
			scl_oe_n_ff  <= 1'b1;
			pin_zero_ff  <= 1'b0;
			rx_valid_ff  <= 1'b0;
			rx_data_ff   <= 8'h00;
			done_ff      <= 1'b0;
			nack_ff      <= 1'b0;
			lost_ff      <= 1'b0;
			addressed_ff <= 1'b0;
			gc_hit_ff    <= 1'b0;
			slave_tx_ff  <= 1'b0;
			busy_out_ff  <= 1'b0;
		end else begin
			sda_oe_n_ff  <= !(m_sda_low_ff || s_sda_low_ff);
			scl_oe_n_ff  <= !(m_scl_low_ff || s_scl_low_ff);
			pin_zero_ff  <= 1'b0;
			rx_valid_ff  <= m_rxbyte || s_rxbyte;
			if (m_rxbyte) begin
				rx_data_ff <= sh_ff;
			end else if (s_rxbyte) begin
				rx_data_ff <= s_sh_ff;
			end
			done_ff      <= m_done;
			nack_ff      <= m_nack;
			lost_ff      <= m_lost;
			addressed_ff <= s_addr_ev;
			gc_hit_ff    <= s_addr_ev &&
				(s_sh_ff[7:1] == i2ce_pkg::GEN_CALL_ADDR);
			slave_tx_ff  <= (state_ff == i2ce_pkg::ST_SLAVE) && s_tx_ff &&
				s_act_ff;
			busy_out_ff  <= (state_ff != i2ce_pkg::ST_IDLE);
		end
	end

	assign o_sda       = pin_zero_ff;
	assign o_scl       = pin_zero_ff;
	assign o_sda_oe_n  = sda_oe_n_ff;
	assign o_scl_oe_n  = scl_oe_n_ff;
	assign o_rx_valid  = rx_valid_ff;
	assign o_rx_data   = rx_data_ff;
	assign o_done      = done_ff;
	assign o_nack      = nack_ff;
	assign o_arb_lost  = lost_ff;
	assign o_addressed = addressed_ff;
	assign o_gc_hit    = gc_hit_ff;
	assign o_slave_tx  = slave_tx_ff;
	assign o_busy      = busy_out_ff;

	// Transmit data for master writes and slave reads
	i2ce_fifo #(
		.WIDTH (i2ce_pkg::FIFO_WIDTH),
		.DEPTH (i2ce_pkg::FIFO_DEPTH)
	) u_tx_fifo (
		.i_clk       (i_clk),
		.i_rst_n     (rst_n_ff),
		.i_in_valid  (i_tx_valid),
		.i_in_data   (i_tx_data),
		.o_in_ready  (o_tx_ready),
		.o_out_valid (fifo_valid),
		.o_out_data  (fifo_data),
		.i_out_ready (m_load || s_take)
	);

endmodule : i2ce_engine

// ==== sim/i2ce_assertions.sv ====
/*
 * Port checks for the two-wire engine.
 * Assumes it is bound into i2ce_engine.
 */
`timescale 1ns/10ps

module i2ce_checker (
	// Clock and reset
	input wire logic       i_clk,
	input wire logic       i_resetn,
	// Pins and control
	input wire logic       o_sda,
	input wire logic       o_scl,
	input wire logic       o_sda_oe_n,
	input wire logic       o_scl_oe_n,
	input wire logic       i_general_call_enable,
	// Status
	input wire logic       o_rx_valid,
	input wire logic [7:0] o_rx_data,
	input wire logic       o_busy,
	input wire logic       o_done,
	input wire logic       o_nack,
	input wire logic       o_arb_lost,
	input wire logic       o_addressed,
	input wire logic       o_gc_hit,
	input wire logic       o_slave_tx
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	chk_pins_low: assert property (o_sda == 1'h0 && o_scl == 1'h0)
		else $error("pin level not low");
	chk_start_first: assert property ($rose(o_busy) |-> o_scl_oe_n [*8])
		else $error("clock pulled at start");
	chk_done_free: assert property (o_done |-> ##1 (o_sda_oe_n && o_scl_oe_n))
		else $error("lines held after stop");
	chk_done_idle: assert property (o_done |-> ##[0:2] !o_busy)
		else $error("busy after stop");
	chk_arb_free: assert property (o_arb_lost |->
		(o_sda_oe_n && o_scl_oe_n) [*4])
		else $error("lines held after lost arbitration");
	chk_nack_stop: assert property (o_nack |-> ##[0:1000] o_done)
		else $error("no stop after nack");
	chk_rx_hold: assert property ($changed(o_rx_data) |-> o_rx_valid)
		else $error("rx data moved without valid");
	chk_gc_gate: assert property (o_gc_hit |->
		o_addressed && i_general_call_enable)
		else $error("general call while disabled");
	chk_stx_busy: assert property (o_slave_tx |-> o_busy)
		else $error("slave tx while idle");

	cover property (o_done);
	cover property (o_nack);
	cover property (o_rx_valid);
endmodule : i2ce_checker

// ==== sim/i2ce_slave_model.sv ====
/*
 * Behavioural slave on the shared bus: acks its address, takes writes,
 * answers reads with one byte. Assumes pull-ups resolve both lines.
 */
`timescale 1ns/10ps

module i2ce_slave_model #(
	parameter logic [6:0] SLV_ADDR = 7'h5A,
	parameter logic [7:0] RD_BYTE  = 8'hC3
) (
	// Bus
	input  wire logic       sda,
	input  wire logic       scl,
	output logic            m_low,
	// Observations
	output logic [7:0]      m_addr,
	output logic [7:0]      m_first,
	output logic [7:0]      m_last,
	output logic [7:0]      m_cnt,
	output logic            m_ack
);
	logic [7:0] b;

	// Bits taken on clock rise, msb first
	task automatic get_byte();
		for (int i = 7; i >= 0; i--) begin
			@(posedge scl);
			b[i] = sda;
		end
		@(negedge scl);
	endtask : get_byte

	// Hold past the fall so the master sees stable data
	task automatic ack_slot(input logic a);
		#100 m_low = a;
		@(negedge scl);
		#100 m_low = 1'b0;
	endtask : ack_slot

	initial begin
		m_low = 1'b0;
		m_cnt = 8'h00;
		forever begin : body
			@(negedge sda iff scl === 1'b1);
			get_byte();
			m_addr = b;
			if (b[7:1] == SLV_ADDR) begin
				ack_slot(1'b1);
				if (b[0]) begin
					for (int i = 7; i >= 0; i--) begin
						m_low = !RD_BYTE[i];
						@(negedge scl);
						#100;
					end
					m_low = 1'b0;
					@(posedge scl);
					m_ack = !sda;
				end else begin
					m_cnt = 8'h00;
					forever begin
						get_byte();
						ack_slot(1'b1);
						if (m_cnt == 8'h00) m_first = b;
						m_last = b;
						m_cnt++;
					end
				end
			end
		end
	end

	// Stop ends any frame in progress
	always @(posedge sda) if (scl === 1'b1) begin
		disable body;
		m_low = 1'b0;
	end
endmodule : i2ce_slave_model

// ==== sim/tb_i2ce_master_protocol_engine.sv ====
/*
 * Bench for the two-wire engine: fifo fill and write, reads, nack.
 * Assumes one slave model on a pulled-up bus.
 */
`timescale 1ns/10ps

module tb_i2ce_master_protocol_engine;
	logic       i_clk = 1'h0, i_resetn = 1'h0, i_fast_mode = 1'h1;
	logic       i_ack_assert_bit = 1'h1, i_start = 1'h0, i_rw = 1'h0;
	logic       i_tx_valid = 1'h0;
	logic [6:0] i_addr = 7'h00;
	logic [7:0] i_len = 8'h00, i_tx_data = 8'h00;
	logic       o_sda, o_sda_oe_n, o_scl, o_scl_oe_n, o_tx_ready;
	logic       o_rx_valid, o_busy, o_done, o_nack, o_arb_lost;
	logic       o_addressed, o_gc_hit, o_slave_tx, m_low, m_ack;
	logic [7:0] o_rx_data, m_addr, m_first, m_last, m_cnt, rx_last;
	logic [7:0] done_n = 8'h00, nack_n = 8'h00, rx_n = 8'h00;
	logic [7:0] starts = 8'h00, stops = 8'h00, d0, n0, r0, s0, p0;
	logic       tb_sda_low = 1'h0, tb_scl_low = 1'h0;
	logic       i_general_call_enable = 1'h0;
	logic [7:0] adr_n = 8'h00, gc_n = 8'h00, q0, g0;
	int         fails = 0, samples_checked = 0, cyc = 0;
	// Pull-ups: a released line reads high
	wire sda = (o_sda_oe_n === 1'b0 ? o_sda : 1'b1) & ~m_low &
		~tb_sda_low;
	wire scl = (o_scl_oe_n === 1'b0 ? o_scl : 1'b1) & ~tb_scl_low;

	always #12.5 i_clk = ~i_clk;

	i2ce_engine DUT (
		.i_clk(i_clk), .i_resetn(i_resetn),
		.i_sda(sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
		.i_scl(scl), .o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n),
		.i_fast_mode(i_fast_mode), .i_ack_assert_bit(i_ack_assert_bit),
		.i_general_call_enable(i_general_call_enable),
		.i_own_address_register(7'h33),
		.i_start(i_start), .i_addr(i_addr), .i_rw(i_rw), .i_len(i_len),
		.i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data),
		.o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid),
		.o_rx_data(o_rx_data), .o_busy(o_busy), .o_done(o_done),
		.o_nack(o_nack), .o_arb_lost(o_arb_lost),
		.o_addressed(o_addressed), .o_gc_hit(o_gc_hit),
		.o_slave_tx(o_slave_tx)
	);

	i2ce_slave_model u_slave (
		.sda(sda), .scl(scl), .m_low(m_low), .m_addr(m_addr),
		.m_first(m_first), .m_last(m_last), .m_cnt(m_cnt), .m_ack(m_ack)
	);

	// Pulses are counted here, so a scenario never misses one
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (o_done === 1'b1) done_n <= done_n + 8'h01;
		if (o_nack === 1'b1) nack_n <= nack_n + 8'h01;
		if (o_addressed === 1'b1) adr_n <= adr_n + 8'h01;
		if (o_gc_hit === 1'b1) gc_n <= gc_n + 8'h01;
		if (o_rx_valid === 1'b1) begin
			rx_n <= rx_n + 8'h01;
			rx_last <= o_rx_data;
		end
		if (cyc == 60000) begin
			fails++;
			wrap_up();
		end
	end
	always @(negedge sda) if (scl === 1'b1) starts++;
	always @(posedge sda) if (scl === 1'b1) stops++;

	task check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task snap();
		d0 = done_n;
		n0 = nack_n;
		r0 = rx_n;
		s0 = starts;
		p0 = stops;
		q0 = adr_n;
		g0 = gc_n;
	endtask : snap

	// Bench plays master: one line state held for 21 cycles
	task bb(input logic s, input logic c);
		@(posedge i_clk);
		tb_sda_low <= !s;
		tb_scl_low <= !c;
		repeat (20) @(posedge i_clk);
	endtask : bb

	task bb_byte(input logic [7:0] v, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bb(v[i], 1'b0);
			bb(v[i], 1'b1);
		end
		bb(1'b1, 1'b0);
		bb(1'b1, 1'b1);
		ack = !sda;
	endtask : bb_byte

	task slv(input logic [6:0] a, input logic g, input logic ea);
		logic ak;
		snap();
		@(posedge i_clk);
		i_general_call_enable <= g;
		bb(1'b1, 1'b1);
		bb(1'b0, 1'b1);
		bb_byte({a, 1'b0}, ak);
		check(ak, ea);
		bb_byte(8'h5C, ak);
		check(ak, ea);
		bb(1'b0, 1'b0);
		bb(1'b0, 1'b1);
		bb(1'b1, 1'b1);
		repeat (4) @(negedge i_clk);
		check(adr_n - q0, ea);
		check(gc_n - g0, {7'h00, g && (a == 7'h00)});
		check(rx_n - r0, ea);
		if (ea) check(rx_last, 8'h5C);
	endtask : slv

	task t_slave();
		slv(7'h33, 1'b0, 1'b1);
		slv(7'h00, 1'b1, 1'b1);
		slv(7'h00, 1'b0, 1'b0);
		$display("slave test ended");
	endtask : t_slave

	task wait_busy(input logic v);
		int k;
		k = 0;
		do begin
			@(negedge i_clk);
			k++;
		end while (o_busy !== v && k < 50000);
	endtask : wait_busy

	task push(input logic [7:0] d);
		@(posedge i_clk);
		i_tx_valid <= 1'b1;
		i_tx_data <= d;
		do @(posedge i_clk); while (o_tx_ready !== 1'b1);
		i_tx_valid <= 1'b0;
	endtask : push

	// Command held until busy shows it was taken
	task run(input logic [6:0] a, input logic r, input logic [7:0] n);
		snap();
		@(posedge i_clk);
		i_addr <= a;
		i_rw <= r;
		i_len <= n;
		i_start <= 1'b1;
		wait_busy(1'b1);
		@(posedge i_clk);
		i_start <= 1'b0;
		wait_busy(1'b0);
		repeat (4) @(negedge i_clk);
	endtask : run

	task t_fill_write();
		for (int i = 0; i < 8; i++) push(8'h12 + 8'h11 * i[7:0]);
		repeat (3) @(negedge i_clk);
		check(o_tx_ready, 8'h00);
		run(7'h5A, 1'b0, 8'h08);
		check(m_addr, 8'hB4);
		check(m_first, 8'h12);
		check(m_last, 8'h89);
		check(m_cnt, 8'h08);
		check(starts - s0, 8'h01);
		check(stops - p0, 8'h01);
		check(done_n - d0, 8'h01);
		check(nack_n - n0, 8'h00);
		check(o_tx_ready, 8'h01);
		$display("fill and write test ended");
	endtask : t_fill_write

	// Standard rate here, the write used the fast one
	task t_read();
		for (int a = 0; a < 2; a++) begin
			@(posedge i_clk);
			i_fast_mode <= 1'b0;
			i_ack_assert_bit <= a[0];
			run(7'h5A, 1'b1, 8'h01);
			check(m_addr, 8'hB5);
			check(rx_last, 8'hC3);
			check(rx_n - r0, 8'h01);
			check(m_ack, {7'h00, a[0]});
			check(done_n - d0, 8'h01);
		end
		$display("read test ended");
	endtask : t_read

	task t_nack();
		@(posedge i_clk);
		i_fast_mode <= 1'b1;
		run(7'h21, 1'b0, 8'h01);
		check(m_addr, 8'h42);
		check(nack_n - n0, 8'h01);
		check(stops - p0, 8'h01);
		check(done_n - d0, 8'h01);
		$display("nack test ended");
	endtask : t_nack

	task wrap_up();
		$display("checked %0d, failed %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (4) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (5) @(posedge i_clk);
		t_fill_write();
		t_read();
		t_nack();
		t_slave();
		wrap_up();
	end
endmodule : tb_i2ce_master_protocol_engine

bind i2ce_engine i2ce_checker u_chk (
	.i_clk, .i_resetn, .o_sda, .o_scl, .o_sda_oe_n, .o_scl_oe_n,
	.i_general_call_enable, .o_rx_valid, .o_rx_data, .o_busy, .o_done,
	.o_nack, .o_arb_lost, .o_addressed, .o_gc_hit, .o_slave_tx
);
